/* inc/gap_sched_defines.vh */
// Constants for the compressed-mode gap scheduler block
`ifndef GAP_SCHED_DEFINES_VH
`define GAP_SCHED_DEFINES_VH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_CFG         8'h04
`define OFS_STATUS      8'h08
`define OFS_POSITION    8'h0C
`define OFS_SPLIT       8'h10
`define OFS_SPREAD      8'h14
`define OFS_TIMING      8'h18

// Control register fields
`define CTRL_ENABLE_BIT 0

// Configuration register fields
`define CFG_LEN_LSB     0
`define CFG_LEN_MSB     3
`define CFG_START_LSB   4
`define CFG_START_MSB   7
`define CFG_ADJ_BIT     8
`define CFG_DOUBLE_BIT  9
`define CFG_METHOD_BIT  10
`define CFG_FIRST1_LSB  12
`define CFG_FIRST1_MSB  15
`define CFG_RESET       32'h0000_0003

// Frame timing
`define SLOTS_PER_FRAME 4'hF
`define MIN_TX_SLOTS    4'h8
`define LAST_SLOT       4'hE

// Spreading ratio limits, as log2 of the ratio
`define SPREAD_MIN_LOG2 4'h2
`define SPREAD_MAX_PUNC 4'h9
`define SPREAD_MAX_HALF 4'h8

`endif

/* core/gap_calc.v */
// Combinational gap placement and validity calculator
`timescale 1ns/1ps
`include "gap_sched_defines.vh"

module gap_calc
(
   input  wire [3:0] len,
   input  wire [3:0] start,
   input  wire       adjustable,
   input  wire       double_frame,
   input  wire [3:0] first_part,
   output reg  [3:0] first_slot,
   output reg  [3:0] last_slot,
   output reg        wraps,
   output reg  [3:0] idle_first,
   output reg  [3:0] idle_second,
   output reg        cfg_error
);

   function len_ok;
      input [3:0] l;
      begin
         len_ok = (l == 4'h3) || (l == 4'h4) || (l == 4'h7) ||
                  (l == 4'hA) || (l == 4'hE);
      end
   endfunction

   reg [4:0] sum;
   reg [4:0] end_idx;
   reg [3:0] lo_split;
   reg [3:0] hi_split;

   always @*
   begin
      first_slot  = 4'h0;
      last_slot   = 4'h0;
      wraps       = 1'b0;
      idle_first  = 4'h0;
      idle_second = 4'h0;
      cfg_error   = !len_ok(len);                        // see R02
      lo_split    = 4'h1;
      hi_split    = 4'h1;
      sum         = 5'h00;
      end_idx     = 5'h00;
      if (adjustable)                                    // see R01
      begin
         cfg_error  = cfg_error || (start > `LAST_SLOT); // see R03
         first_slot = start;
         sum        = {1'b0, start} + {1'b0, len};
         end_idx    = sum - 5'h01;
         if (sum <= {1'b0, `SLOTS_PER_FRAME})
         begin
            last_slot  = end_idx[3:0];                   // see R04
            idle_first = len;
         end
         else
         begin
            // mod 15 of a value below 30 is one subtraction
            last_slot   = end_idx[3:0] - `SLOTS_PER_FRAME; // see R05
            wraps       = 1'b1;
            idle_first  = `SLOTS_PER_FRAME - start;
            idle_second = len - idle_first;
         end
      end
      else if (!double_frame)
      begin
         case (len)                                      // see R07
            4'h3:
            begin
               first_slot = 4'h7;
               last_slot  = 4'h9;
            end
            4'h4:
            begin
               first_slot = 4'h6;
               last_slot  = 4'h9;
            end
            4'h7:
            begin
               first_slot = 4'h6;
               last_slot  = 4'hC;
            end
            default: cfg_error = 1'b1;
         endcase
         idle_first = len;
      end
      else
      begin
         wraps = 1'b1;
         case (len)                                      // see R08
            4'h3:
            begin
               first_slot = 4'hE;
               last_slot  = 4'h1;
            end
            4'h4:
            begin
               first_slot = 4'hD;
               last_slot  = 4'h1;
            end
            4'h7:
            begin
               first_slot = 4'hC;
               last_slot  = 4'h3;
            end
            4'hA:
            begin
               first_slot = 4'hA;
               last_slot  = 4'h4;
            end
            4'hE:
            begin
               first_slot = 4'h8;
               last_slot  = 4'h6;
            end
            default: cfg_error = 1'b1;
         endcase
         idle_first  = `SLOTS_PER_FRAME - first_slot;
         idle_second = len - idle_first;
      end
      // A requested first-frame share overrides idle_first and idle_second, not first_slot and last_slot
      if (double_frame && !adjustable && first_part != 4'h0)
      begin
         idle_first  = first_part;
         idle_second = len - first_part;
      end
      if (wraps)
      begin
         case (len)                                      // see R09
            4'h3:    hi_split = 4'h2;
            4'h4:    hi_split = 4'h3;
            4'h7:    hi_split = 4'h6;
            4'hA:
            begin
               lo_split = 4'h3;
               hi_split = 4'h7;
            end
            default:
            begin
               lo_split = 4'h7;
               hi_split = 4'h7;
            end
         endcase
         if (idle_first < lo_split || idle_first > hi_split)
            cfg_error = 1'b1;                            // see R11
         // Each frame keeps at least eight transmitted slots
         if (idle_first > `SLOTS_PER_FRAME - `MIN_TX_SLOTS ||
             idle_second > `SLOTS_PER_FRAME - `MIN_TX_SLOTS)
            cfg_error = 1'b1;                            // see R06
      end
   end

endmodule // gap_calc

/* core/gap_scheduler.v */
// Compressed-mode gap scheduler with AHB-Lite register access
//
// What this block does
// R01 - Gap placement fixed or adjustable, per purpose
// R02 - Gap length only 3, 4, 7, 10, 14
// R03 - Adjustable first idle slot is 0 to 14
// R04 - Short gap ends at first plus length minus one
// R05 - Wrapping gap end taken modulo 15, next frame
// R06 - Split gap leaves eight transmitted slots per frame
// R07 - Fixed single-frame slots 7-9, 6-9, 6-12
// R08 - Fixed double-frame start and end slots table
// R09 - Double-frame idle split limited per gap length
// R10 - Spread ratio range 512-4 punctured, 256-4 halved
// R11 - Bad configuration flags error, suppresses gap
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "gap_sched_defines.vh"

module gap_scheduler
(
   input  wire        CLK_SYS,
   input  wire        RESETN,
   input  wire        HSEL,
   input  wire [31:0] HADDR,
   input  wire [1:0]  HTRANS,
   input  wire        HWRITE,
   input  wire [2:0]  HSIZE,
   input  wire [31:0] HWDATA,
   input  wire        HREADY,
   output wire [31:0] HRDATA,
   output wire        HREADYOUT,
   output wire        HRESP,
   input  wire        FRAME_START,
   input  wire        SLOT_TICK,
   output wire        GAP_IDLE,
   output wire [3:0]  SLOT_NUM,
   output wire        CFG_ERROR
);

   ////////////////////////////////////////////////////////////////////////
   // Reset release

   reg rst_meta_ff;
   reg rst_sync_ff;
   wire rst_n = rst_sync_ff;

   always @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus slave: zero wait states, always OKAY

   reg        wr_pend_ff;
   reg [7:0]  addr_ff;
   reg        enable_ff;
   reg [31:0] cfg_ff;
   reg [31:0] rdata_ff;

   wire take = HSEL && HREADY && HTRANS[1];
   wire [7:0] a_ofs = {HADDR[7:2], 2'b00};
   wire unmapped = |HADDR[31:8];

   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign HRDATA    = rdata_ff;

   always @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_pend_ff <= 1'b0;
         addr_ff    <= 8'h00;
      end
      else
      begin
         wr_pend_ff <= take && HWRITE && !unmapped;
         addr_ff    <= a_ofs;
      end
   end

   // Config writes are held until the next frame start so a gap is never
   // rebuilt halfway through a frame.
   reg [31:0] shadow_ff;
   reg        shadow_vld_ff;

   always @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enable_ff     <= 1'b0;
         shadow_ff     <= `CFG_RESET;
         shadow_vld_ff <= 1'b0;
         cfg_ff        <= `CFG_RESET;
      end
      else
      begin
         if (wr_pend_ff && addr_ff == `OFS_CTRL)
            enable_ff <= HWDATA[`CTRL_ENABLE_BIT];
         if (wr_pend_ff && addr_ff == `OFS_CFG)
         begin
            shadow_ff     <= HWDATA;
            shadow_vld_ff <= 1'b1;
         end
         else if (FRAME_START && shadow_vld_ff)
         begin
            cfg_ff        <= shadow_ff;
            shadow_vld_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Gap calculation

   wire [3:0] len    = cfg_ff[`CFG_LEN_MSB:`CFG_LEN_LSB];
   wire [3:0] start  = cfg_ff[`CFG_START_MSB:`CFG_START_LSB];
   wire       adj    = cfg_ff[`CFG_ADJ_BIT];
   wire       dbl    = cfg_ff[`CFG_DOUBLE_BIT];
   wire       method = cfg_ff[`CFG_METHOD_BIT];
   wire [3:0] part1  = cfg_ff[`CFG_FIRST1_MSB:`CFG_FIRST1_LSB];

   wire [3:0] first_slot;
   wire [3:0] last_slot;
   wire       wraps;
   wire [3:0] idle_first;
   wire [3:0] idle_second;
   wire       calc_err;

   gap_calc u_calc
   (
      .len          (len),
      .start        (start),
      .adjustable   (adj),
      .double_frame (dbl),
      .first_part   (part1),
      .first_slot   (first_slot),
      .last_slot    (last_slot),
      .wraps        (wraps),
      .idle_first   (idle_first),
      .idle_second  (idle_second),
      .cfg_error    (calc_err)
   );

   // Method 0 punctures (ratio down from 512), method 1 halves it (256)
   wire [3:0] spread_max = method ? `SPREAD_MAX_HALF
                                  : `SPREAD_MAX_PUNC;   // see R10
   wire [3:0] spread_min = `SPREAD_MIN_LOG2;             // see R10

   ////////////////////////////////////////////////////////////////////////
   // Slot and frame tracking

   reg [3:0] slot_ff;
   reg       in_second_ff;
   reg       gap_ff;
   reg       err_ff;
   reg [3:0] nxt_slot;
   reg       nxt_second;
   reg       nxt_gap;

   always @*
   begin
      nxt_slot   = slot_ff;
      nxt_second = in_second_ff;
      if (FRAME_START)
      begin
         nxt_slot   = 4'h0;
         // The second frame follows a frame whose gap wrapped
         nxt_second = gap_ff && wraps && !in_second_ff;
      end
      else if (SLOT_TICK && slot_ff != `LAST_SLOT)
         nxt_slot = slot_ff + 4'h1;
      nxt_gap = 1'b0;
      if (enable_ff && !calc_err)                        // see R11
      begin
         if (nxt_second)
            nxt_gap = (nxt_slot <= last_slot);           // see R05
         else if (wraps)
            nxt_gap = (nxt_slot >= first_slot);          // see R08
         else
            nxt_gap = (nxt_slot >= first_slot) &&
                      (nxt_slot <= last_slot);           // see R04
      end
   end

   always @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         slot_ff      <= 4'h0;
         in_second_ff <= 1'b0;
         gap_ff       <= 1'b0;
         err_ff       <= 1'b0;
      end
      else
      begin
         slot_ff      <= nxt_slot;
         in_second_ff <= nxt_second;
         gap_ff       <= nxt_gap;
         err_ff       <= calc_err;
      end
   end

   assign GAP_IDLE  = gap_ff;
   assign SLOT_NUM  = slot_ff;
   assign CFG_ERROR = err_ff;

   ////////////////////////////////////////////////////////////////////////
   // Read data

   reg [31:0] nxt_rdata;

   always @*
   begin
      case (a_ofs)
         `OFS_CTRL:     nxt_rdata = {31'h0000_0000, enable_ff};
         `OFS_CFG:      nxt_rdata = cfg_ff;
         `OFS_STATUS:   nxt_rdata = {26'h000_0000, shadow_vld_ff,
                                     in_second_ff, wraps, gap_ff,
                                     calc_err, enable_ff};
         `OFS_POSITION: nxt_rdata = {24'h00_0000, last_slot, first_slot};
         `OFS_SPLIT:    nxt_rdata = {24'h00_0000, idle_second, idle_first};
         `OFS_SPREAD:   nxt_rdata = {24'h00_0000, spread_max, spread_min};
         `OFS_TIMING:   nxt_rdata = {28'h000_0000, slot_ff};
         default:       nxt_rdata = 32'h0000_0000;
      endcase
      if (unmapped)
         nxt_rdata = 32'h0000_0000;
   end

   always @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
         rdata_ff <= 32'h0000_0000;
      else if (take && !HWRITE)
         rdata_ff <= nxt_rdata;
   end

endmodule // gap_scheduler

/* verif/slot_timer_model.sv */
// Slot and frame strobe source standing in for the physical channel
`timescale 1ns/1ps
module slot_timer_model
#(
   parameter int TICK_GAP = 4
)
(
   input  wire logic  clk,
   input  wire logic  run,
   output logic       frame_start,
   output logic [3:0] slot_idx,
   output logic       slot_tick
);
   int cnt;
   initial
   begin
      cnt = 0;
      frame_start = 1'b0;
      slot_tick = 1'b0;
      slot_idx = 4'hE;
   end
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      frame_start <= 1'b0;
      slot_tick <= 1'b0;
      if (run)
      begin
         cnt <= (cnt == TICK_GAP - 1) ? 0 : cnt + 1;
         if (cnt == 0)
         begin
            // Fifteen slots a frame; never ticks past the last slot
            frame_start <= (slot_idx == 4'hE);
            slot_tick <= (slot_idx != 4'hE);
            slot_idx <= (slot_idx == 4'hE) ? 4'h0 : slot_idx + 4'h1;
         end
      end
   end
endmodule // slot_timer_model

/* verif/gap_scheduler_monitor.sv */
// Port-level checker for the gap scheduler
`timescale 1ns/1ps
module gap_scheduler_monitor
(
   input wire       CLK_SYS,
   input wire       RESETN,
   input wire       HREADYOUT,
   input wire       HRESP,
   input wire       FRAME_START,
   input wire       SLOT_TICK,
   input wire       GAP_IDLE,
   input wire [3:0] SLOT_NUM,
   input wire       CFG_ERROR
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   sequence s_new_frame;
      FRAME_START;
   endsequence
   sequence s_first_tick;
      SLOT_TICK && !FRAME_START;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   AST_READY: assert property (HREADYOUT == 1'b1)
      else $error("bus stalled");
   AST_OKAY: assert property (HRESP == 1'b0)
      else $error("bus error response");
   AST_SLOT_MAX: assert property (SLOT_NUM <= 4'hE)
      else $error("slot number beyond fourteen");
   AST_FRAME_ZERO: assert property (s_new_frame
      |=> SLOT_NUM == 4'h0)
      else $error("frame start did not clear slot");
   AST_TICK_STEP: assert property ((s_first_tick and SLOT_NUM < 4'hE)
      |=> SLOT_NUM == $past(SLOT_NUM) + 4'h1)
      else $error("slot did not advance by one");
   AST_SLOT_HOLD: assert property (!SLOT_TICK && !FRAME_START
      |=> $stable(SLOT_NUM))
      else $error("slot moved without a strobe");
   // Three quiet cycles match the partner's four-cycle strobe spacing
   AST_FIRST_TICK: assert property (s_new_frame
      ##1 (!SLOT_TICK) [*3] ##1 s_first_tick |=> SLOT_NUM == 4'h1)
      else $error("first tick of frame not slot one");
   AST_ERR_QUIET: assert property (CFG_ERROR && $past(CFG_ERROR)
      |-> !GAP_IDLE)
      else $error("gap active under configuration error");
endmodule // gap_scheduler_monitor

bind gap_scheduler gap_scheduler_monitor i_gap_scheduler_monitor
(
   .CLK_SYS     (CLK_SYS),
   .RESETN      (RESETN),
   .HREADYOUT   (HREADYOUT),
   .HRESP       (HRESP),
   .FRAME_START (FRAME_START),
   .SLOT_TICK   (SLOT_TICK),
   .GAP_IDLE    (GAP_IDLE),
   .SLOT_NUM    (SLOT_NUM),
   .CFG_ERROR   (CFG_ERROR)
);

/* verif/compressed_mode_gap_scheduler_tb_top.sv */
// Self-checking bench for the gap scheduler
`timescale 1ns/1ps
module compressed_mode_gap_scheduler_tb_top;
   typedef struct packed
   {
      logic [15:0] cfg;
      logic [7:0]  pos;
      logic        err;
      logic [7:0]  split;
   } row_t;
   // Position or split of zero means that field is not compared
   row_t rows [0:18] = '{
      '{16'h0003, 8'h97, 1'b0, 8'h00},
      '{16'h0004, 8'h96, 1'b0, 8'h00},
      '{16'h0407, 8'hC6, 1'b0, 8'h00},
      '{16'h000A, 8'h00, 1'b1, 8'h00},
      '{16'h0203, 8'h1E, 1'b0, 8'h00},
      '{16'h0204, 8'h1D, 1'b0, 8'h00},
      '{16'h0207, 8'h3C, 1'b0, 8'h00},
      '{16'h020A, 8'h4A, 1'b0, 8'h00},
      '{16'h020E, 8'h68, 1'b0, 8'h77},
      '{16'h0553, 8'h75, 1'b0, 8'h00},
      '{16'h01B4, 8'hEB, 1'b0, 8'h00},
      '{16'h01E3, 8'h1E, 1'b0, 8'h21},
      '{16'h0105, 8'h00, 1'b1, 8'h00},
      '{16'h019E, 8'h00, 1'b1, 8'h00},
      '{16'h01AA, 8'h4A, 1'b0, 8'h55},
      '{16'h01DA, 8'h00, 1'b1, 8'h00},
      '{16'h3204, 8'h00, 1'b0, 8'h13},
      '{16'h4204, 8'h00, 1'b1, 8'h00},
      '{16'h220A, 8'h00, 1'b1, 8'h00}
   };
   logic        CLK_SYS = 1'b0;
   logic        RESETN = 1'b0;
   logic        HSEL = 1'b0;
   logic [31:0] HADDR = 32'h0000_0000;
   logic [1:0]  HTRANS = 2'b00;
   logic        HWRITE = 1'b0;
   logic [2:0]  HSIZE = 3'b000;
   logic [31:0] HWDATA = 32'h0000_0000;
   logic        run = 1'b0;
   wire  [31:0] HRDATA;
   wire         HREADYOUT;
   wire         HRESP;
   wire         fs;
   wire         tk;
   wire  [3:0]  slot_idx;
   wire         GAP_IDLE;
   wire  [3:0]  SLOT_NUM;
   wire         CFG_ERROR;
   logic [31:0] d;
   int          fails = 0;
   int          checks_done = 0;
   always #2 CLK_SYS = ~CLK_SYS;
   ////////////////////////////////////////////////////////////////////////
   gap_scheduler i_gap_scheduler
   (
      .CLK_SYS (CLK_SYS), .RESETN (RESETN), .HSEL (HSEL),
      .HADDR (HADDR), .HTRANS (HTRANS), .HWRITE (HWRITE),
      .HSIZE (HSIZE), .HWDATA (HWDATA), .HREADY (HREADYOUT),
      .HRDATA (HRDATA), .HREADYOUT (HREADYOUT), .HRESP (HRESP),
      .FRAME_START (fs), .SLOT_TICK (tk), .GAP_IDLE (GAP_IDLE),
      .SLOT_NUM (SLOT_NUM), .CFG_ERROR (CFG_ERROR)
   );
   slot_timer_model i_slot_timer_model
   (
      .clk (CLK_SYS), .run (run), .frame_start (fs),
      .slot_idx (slot_idx), .slot_tick (tk)
   );
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Called just after a rising edge; zero-wait slave, but never assumed
   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HADDR <= a;
      HWRITE <= wr;
      HSIZE <= 3'b010;
      @(posedge CLK_SYS iff HREADYOUT === 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= wd;
      @(posedge CLK_SYS iff HREADYOUT === 1'b1);
      rd = HRDATA;
   endtask
   // Follows n slot strobes; a wrapping gap alternates first and second
   // frames, starting in a first frame
   task automatic walk(input int n, input logic [3:0] lo,
                       input logic [3:0] hi, input logic wrap);
      logic second;
      logic exp_idle;
      second = 1'b0;
      repeat (n)
      begin
         @(posedge CLK_SYS iff (fs || tk));
         if (fs)
            second = wrap && !second;
         repeat (2) @(posedge CLK_SYS);
         if (!wrap)
            exp_idle = slot_idx >= lo && slot_idx <= hi;
         else if (second)
            exp_idle = slot_idx <= hi;
         else
            exp_idle = slot_idx >= lo;
         chk("slot", {28'h0, SLOT_NUM}, {28'h0, slot_idx});
         chk("idle", {31'h0, GAP_IDLE}, {31'h0, exp_idle});
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #(4 * 30000);
      fails++;
      report_and_stop();
   end
   initial
   begin
      repeat (8) @(posedge CLK_SYS);
      chk("idle_in_reset", {31'h0, GAP_IDLE}, 32'h0);
      chk("slot_in_reset", {28'h0, SLOT_NUM}, 32'h0);
      RESETN <= 1'b1;
      repeat (3) @(posedge CLK_SYS);
      bus(1'b0, 32'h04, 32'h0, d);
      chk("cfg_reset", d, 32'h0000_0003);
      bus(1'b0, 32'h00, 32'h0, d);
      chk("ctrl_reset", d, 32'h0000_0000);
      bus(1'b1, 32'h100, 32'hFFFF_FFFF, d);
      bus(1'b0, 32'h100, 32'h0, d);
      chk("unmapped", d, 32'h0000_0000);
      bus(1'b1, 32'h00, 32'h0000_0001, d);
      run <= 1'b1;
      foreach (rows[i])
      begin
         bus(1'b1, 32'h04, {16'h0, rows[i].cfg}, d);
         // A frame is 60 cycles; the shadow lands at the next one
         repeat (70) @(posedge CLK_SYS);
         bus(1'b0, 32'h08, 32'h0, d);
         chk("err_flag", {31'h0, d[1]}, {31'h0, rows[i].err});
         chk("err_pin", {31'h0, CFG_ERROR}, {31'h0, rows[i].err});
         bus(1'b0, 32'h0C, 32'h0, d);
         if (rows[i].pos != 8'h00)
            chk("position", d & 32'hFF, {24'h0, rows[i].pos});
         bus(1'b0, 32'h10, 32'h0, d);
         if (rows[i].split != 8'h00)
            chk("split", d & 32'hFF, {24'h0, rows[i].split});
         bus(1'b0, 32'h14, 32'h0, d);
         if (!rows[i].err)
            chk("spread", d & 32'hFF,
                rows[i].cfg[10] ? 32'h82 : 32'h92);
      end
      @(posedge CLK_SYS iff fs);
      bus(1'b1, 32'h04, 32'h0000_0153, d);
      bus(1'b0, 32'h04, 32'h0, d);
      chk("cfg_before_frame", d, 32'h0000_220A);
      bus(1'b0, 32'h08, 32'h0, d);
      chk("pending", {31'h0, d[5]}, 32'h1);
      @(posedge CLK_SYS iff fs);
      walk(15, 4'h5, 4'h7, 1'b0);
      bus(1'b0, 32'h18, 32'h0, d);
      chk("timing", d, 32'h0000_0000);
      bus(1'b1, 32'h04, 32'h0000_0203, d);
      @(posedge CLK_SYS iff fs);
      walk(30, 4'hE, 4'h1, 1'b1);
      report_and_stop();
   end
endmodule // compressed_mode_gap_scheduler_tb_top
